// *** core/qcop_pkg.sv ***
// shared constants and types of the quadrature counter output port
package qcop_pkg;
  localparam int unsigned QCOP_POS_W = 32;
  localparam int unsigned QCOP_BYTE_W = 8;
  localparam int unsigned QCOP_ADDR_W = 5;
  localparam int unsigned QCOP_SYNC_W = 11;
  // pin levels taken as idle at reset: port enable off, mode selects at 4x
  localparam logic [QCOP_SYNC_W-1:0] QCOP_PIN_RST = 11'h220;
  // byte addresses of the register words
  localparam logic [4:0] QCOP_OFS_CTRL = 5'h00;
  localparam logic [4:0] QCOP_OFS_STATUS = 5'h04;
  localparam logic [4:0] QCOP_OFS_MASK = 5'h08;
  localparam logic [4:0] QCOP_OFS_POS1 = 5'h0c;
  localparam logic [4:0] QCOP_OFS_POS2 = 5'h10;
  localparam logic [4:0] QCOP_OFS_MODE = 5'h14;
  // control word fields
  localparam int unsigned QCOP_CTRL_CLR1 = 0;
  localparam int unsigned QCOP_CTRL_CLR2 = 1;
  localparam int unsigned QCOP_CTRL_EN = 2;
  localparam logic [31:0] QCOP_CTRL_RST = 32'h0000_0004;
  // status and mask fields
  localparam int unsigned QCOP_ST_CARRY1 = 0;
  localparam int unsigned QCOP_ST_CARRY2 = 1;
  localparam int unsigned QCOP_ST_BADMODE = 2;
  localparam int unsigned QCOP_ST_W = 3;
  localparam logic [2:0] QCOP_ST_RST = 3'h0;
  localparam logic [2:0] QCOP_MASK_RST = 3'h0;
  localparam logic [QCOP_POS_W-1:0] QCOP_POS_RST = 32'h0000_0000;
  localparam logic [QCOP_POS_W-1:0] QCOP_POS_MAX = 32'hffff_ffff;
  // byte selects: index 0 returns the most significant byte
  localparam logic [1:0] QCOP_BYTE_MSB = 2'h0;
  localparam logic [1:0] QCOP_BYTE_LSB = 2'h3;
  typedef enum logic [1:0] {
    QCOP_MODE_OFF,
    QCOP_MODE_4X,
    QCOP_MODE_2X,
    QCOP_MODE_1X
  } qcop_mode_t;
endpackage

// *** core/qcop_axis.sv ***
// one axis: quadrature decoder, position counter, count and carry pulses
`timescale 1ns/1ps
`default_nettype none
module qcop_axis
  import qcop_pkg::*;
#(
  parameter int unsigned POS_W = 32
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic enable_i,
  input wire qcop_pkg::qcop_mode_t mode_i,
  input wire logic chan_a_i,
  input wire logic chan_b_i,
  output logic count_pulse_o,
  output logic carry_pulse_o,
  output logic direction_o,
  output logic [POS_W-1:0] position_o
);
  logic [1:0] prev_q;
  logic step_up;
  logic step_dn;
  logic qualify;
  logic do_count;
  logic [3:0] trans;

  assign trans = {prev_q, chan_a_i, chan_b_i};
  // gray sequence 00-01-11-10 counts up, the reverse down
  assign step_up = (trans == 4'h1) || (trans == 4'h7) || (trans == 4'he) || (trans == 4'h8);
  assign step_dn = (trans == 4'h2) || (trans == 4'hb) || (trans == 4'hd) || (trans == 4'h4);

  // RULE3: mode decides which steps count
  always_comb
  begin
    case (mode_i)
      QCOP_MODE_4X: qualify = 1'b1;
      QCOP_MODE_2X: qualify = prev_q[1] ^ chan_a_i;
      QCOP_MODE_1X: qualify = (prev_q[1] ^ chan_a_i) && !chan_b_i && !prev_q[0];
      default: qualify = 1'b0;
    endcase
  end

  assign do_count = enable_i && !clear_i && qualify && (step_up || step_dn);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      prev_q <= 2'h0;
    else
      prev_q <= {chan_a_i, chan_b_i};
  end

  // RULE10: pulses rise on the edge that moves the counter
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || clear_i)
    begin
      position_o <= QCOP_POS_RST;
      count_pulse_o <= 1'b0;
      carry_pulse_o <= 1'b0;
    end
    else
    begin
      count_pulse_o <= do_count;
      // RULE4: wrap in either direction gives a carry
      carry_pulse_o <= do_count && ((step_up && position_o == QCOP_POS_MAX) ||
                                    (step_dn && position_o == QCOP_POS_RST));
      if (do_count)
        position_o <= step_up ? position_o + 1'b1 : position_o - 1'b1;
    end
  end

  // RULE9: direction changes only with a counted step
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      direction_o <= 1'b1;
    else if (do_count)
      direction_o <= step_up;
  end

  a_count_moves_pos: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
    count_pulse_o |-> position_o != $past(position_o))
    else $error("count pulse without counter change");
  a_up_step_value: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE9
    count_pulse_o && direction_o |-> position_o == $past(position_o) + 1'b1)
    else $error("direction high but counter did not add one");
  a_carry_at_wrap: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
    carry_pulse_o |-> count_pulse_o &&
      (direction_o ? position_o == QCOP_POS_RST : position_o == QCOP_POS_MAX))
    else $error("carry pulse away from a wrap");
  a_pulse_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    carry_pulse_o |=> !carry_pulse_o)
    else $error("carry pulse longer than one clock");
endmodule
`default_nettype wire

// *** core/qcop_top.sv ***
// quadrature counter output port: two axes, byte read port, avalon registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: the host fixes both count mode selects before decoding starts.
// RULE2: axis select low reads the first axis, high reads the second.
// RULE3: each axis pulses its count output on every step that the chosen mode counts.
// RULE4: each axis pulses its carry output when its counter wraps up or down.
// RULE5: an external counter should advance on the rising edge of a carry pulse.
// RULE6: the 32-bit position latch is read through the 8-bit port as four bytes.
// RULE7: the most significant byte comes first and the least significant last.
// RULE8: the test input is held low for normal operation.
// RULE9: each axis direction output is high counting up, low counting down.
// RULE10: count and carry pulses last one clock and rise with the counter update.
module qcop_top
  import qcop_pkg::*;
#(
  parameter int unsigned POS_W = 32
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic axis1_chan_a_i,
  input wire logic axis1_chan_b_i,
  input wire logic axis2_chan_a_i,
  input wire logic axis2_chan_b_i,
  input wire logic count_mode_sel_a_i,
  input wire logic count_mode_sel_b_i,
  input wire logic axis_sel_i,
  input wire logic [1:0] byte_sel_i,
  input wire logic read_en_n_i,
  input wire logic test_i,
  output logic axis1_count_pulse_o,
  output logic axis2_count_pulse_o,
  output logic axis1_carry_pulse_o,
  output logic axis2_carry_pulse_o,
  output logic axis1_direction_o,
  output logic axis2_direction_o,
  output logic [qcop_pkg::QCOP_BYTE_W-1:0] read_port_o,
  output logic read_port_oe_o,
  input wire logic [qcop_pkg::QCOP_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  import qcop_pkg::*;

  logic [QCOP_SYNC_W-1:0] pins;
  logic [QCOP_SYNC_W-1:0] sync1_q;
  logic [QCOP_SYNC_W-1:0] sync2_q;
  logic [QCOP_SYNC_W-1:0] sync3_q;
  logic [QCOP_SYNC_W-1:0] filt_q;
  logic f_a1;
  logic f_b1;
  logic f_a2;
  logic f_b2;
  logic f_msel_a;
  logic f_msel_b;
  logic f_axis_sel;
  logic [1:0] f_byte_sel;
  logic f_read_en_n;
  logic f_test;
  qcop_mode_t mode;
  logic [31:0] ctrl_q;
  logic [QCOP_ST_W-1:0] status_q;
  logic [QCOP_ST_W-1:0] status_d;
  logic [QCOP_ST_W-1:0] mask_q;
  logic ack_q;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] rd_word;
  logic [POS_W-1:0] pos1;
  logic [POS_W-1:0] pos2;
  logic [POS_W-1:0] latch1_q;
  logic [POS_W-1:0] latch2_q;
  logic [POS_W-1:0] sel_latch;
  logic [QCOP_BYTE_W-1:0] sel_byte;
  logic count_en;
  logic clr1;
  logic clr2;

  assign pins = {test_i, read_en_n_i, byte_sel_i, axis_sel_i, count_mode_sel_b_i,
                 count_mode_sel_a_i, axis2_chan_b_i, axis2_chan_a_i, axis1_chan_b_i,
                 axis1_chan_a_i};

  // three stages; a level is taken only once stages two and three agree
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= QCOP_PIN_RST;
      sync2_q <= QCOP_PIN_RST;
      sync3_q <= QCOP_PIN_RST;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // idle reset levels avoid a false port enable or illegal mode after reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      filt_q <= QCOP_PIN_RST;
    else
      for (int i = 0; i < QCOP_SYNC_W; i++)
        if (sync2_q[i] == sync3_q[i])
          filt_q[i] <= sync3_q[i];
  end

  assign f_a1 = filt_q[0];
  assign f_b1 = filt_q[1];
  assign f_a2 = filt_q[2];
  assign f_b2 = filt_q[3];
  assign f_msel_a = filt_q[4];
  assign f_msel_b = filt_q[5];
  assign f_axis_sel = filt_q[6];
  assign f_byte_sel = filt_q[8:7];
  assign f_read_en_n = filt_q[9];
  assign f_test = filt_q[10];

  // select lines 00 are illegal and stop counting
  always_comb
  begin
    case ({f_msel_a, f_msel_b})
      2'b01: mode = QCOP_MODE_4X;
      2'b10: mode = QCOP_MODE_2X;
      2'b11: mode = QCOP_MODE_1X;
      default: mode = QCOP_MODE_OFF;
    endcase
  end

  // a raised test pin freezes both counters rather than running test logic
  assign count_en = ctrl_q[QCOP_CTRL_EN] && !f_test;
  assign clr1 = ctrl_q[QCOP_CTRL_CLR1];
  assign clr2 = ctrl_q[QCOP_CTRL_CLR2];

  qcop_axis #(
    .POS_W(POS_W)
  ) u_axis1 (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clr1),
    .enable_i(count_en),
    .mode_i(mode),
    .chan_a_i(f_a1),
    .chan_b_i(f_b1),
    .count_pulse_o(axis1_count_pulse_o),
    .carry_pulse_o(axis1_carry_pulse_o),
    .direction_o(axis1_direction_o),
    .position_o(pos1)
  );

  qcop_axis #(
    .POS_W(POS_W)
  ) u_axis2 (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clr2),
    .enable_i(count_en),
    .mode_i(mode),
    .chan_a_i(f_a2),
    .chan_b_i(f_b2),
    .count_pulse_o(axis2_count_pulse_o),
    .carry_pulse_o(axis2_carry_pulse_o),
    .direction_o(axis2_direction_o),
    .position_o(pos2)
  );

  // latch freezes while the port is enabled so four bytes form one sample
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      latch1_q <= QCOP_POS_RST;
      latch2_q <= QCOP_POS_RST;
    end
    else if (f_read_en_n)
    begin
      latch1_q <= pos1;
      latch2_q <= pos2;
    end
  end

  // RULE2: axis select picks the latch
  assign sel_latch = f_axis_sel ? latch2_q : latch1_q;

  // RULE7: byte index zero is the top byte
  always_comb
  begin
    case (f_byte_sel)
      QCOP_BYTE_MSB: sel_byte = sel_latch[31:24];
      2'h1: sel_byte = sel_latch[23:16];
      2'h2: sel_byte = sel_latch[15:8];
      default: sel_byte = sel_latch[7:0];
    endcase
  end

  // RULE6: registered byte port with its own drive enable
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      read_port_o <= 8'h00;
      read_port_oe_o <= 1'b0;
    end
    else
    begin
      read_port_o <= sel_byte;
      read_port_oe_o <= !f_read_en_n;
    end
  end

  // one wait cycle per access keeps read data registered
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign rd_hit = avs_read_i && !ack_q;
  // writes land only at the edge where the request is accepted
  assign wr_hit = avs_write_i && ack_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
  end

  always_comb
  begin
    case (avs_address_i)
      QCOP_OFS_CTRL: rd_word = ctrl_q;
      QCOP_OFS_STATUS: rd_word = {29'h0, status_q};
      QCOP_OFS_MASK: rd_word = {29'h0, mask_q};
      QCOP_OFS_POS1: rd_word = pos1;
      QCOP_OFS_POS2: rd_word = pos2;
      QCOP_OFS_MODE: rd_word = {30'h0, mode};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (rd_hit)
      avs_readdata_o <= rd_word;
  end

  // clear bits act for a single cycle, then fall back by themselves
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      ctrl_q <= QCOP_CTRL_RST;
    else if (wr_hit && avs_address_i == QCOP_OFS_CTRL && avs_byteenable_i[0])
      ctrl_q <= {29'h0, avs_writedata_i[2:0]};
    else
      ctrl_q <= {29'h0, ctrl_q[QCOP_CTRL_EN], 2'b00};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      mask_q <= QCOP_MASK_RST;
    else if (wr_hit && avs_address_i == QCOP_OFS_MASK && avs_byteenable_i[0])
      mask_q <= avs_writedata_i[2:0];
  end

  // write one clears; a new event in the same cycle still sets
  always_comb
  begin
    status_d = status_q;
    if (wr_hit && avs_address_i == QCOP_OFS_STATUS && avs_byteenable_i[0])
      status_d = status_q & ~avs_writedata_i[2:0];
    if (axis1_carry_pulse_o)
      status_d[QCOP_ST_CARRY1] = 1'b1;
    if (axis2_carry_pulse_o)
      status_d[QCOP_ST_CARRY2] = 1'b1;
    if (mode == QCOP_MODE_OFF)
      status_d[QCOP_ST_BADMODE] = 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      status_q <= QCOP_ST_RST;
    else
      status_q <= status_d;
  end

  assign irq_o = |(status_q & mask_q);

  a_axis_sel_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
    $past(f_read_en_n == 1'b0 && f_byte_sel == QCOP_BYTE_LSB) |->
      read_port_o == $past(f_axis_sel ? latch2_q[7:0] : latch1_q[7:0]))
    else $error("read port shows the wrong axis");
  a_msb_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    $past(f_byte_sel == QCOP_BYTE_MSB) |-> read_port_o == $past(sel_latch[31:24]))
    else $error("byte zero is not the top byte");
  a_latch_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
    !f_read_en_n && $past(!f_read_en_n) |-> $stable(latch1_q) && $stable(latch2_q))
    else $error("latch moved during a byte read");
  a_bus_answers: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    avs_read_i || avs_write_i |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus access not answered in time");
  a_carry_sticks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
    axis1_carry_pulse_o |=> status_q[QCOP_ST_CARRY1])
    else $error("carry event lost from status");
endmodule
`default_nettype wire

// *** testbench/qcop_ext_cascade.sv ***
// model of an external counter fed by one axis carry pulse
`timescale 1ns/1ps
`default_nettype none
module qcop_ext_cascade
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic carry_pulse_i,
  input wire logic direction_i,
  output logic [7:0] ext_count_o
);
  logic carry_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      carry_q <= 1'b0;
      ext_count_o <= 8'h00;
    end
    else
    begin
      carry_q <= carry_pulse_i;
      if (carry_pulse_i && !carry_q)
        ext_count_o <= direction_i ? ext_count_o + 8'h01 : ext_count_o - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** testbench/test_quadrature_counter_output_port.sv ***
// self-checking bench of the quadrature counter output port
`timescale 1ns/1ps
`default_nettype none
module test_quadrature_counter_output_port;
  import qcop_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] ph1 = 2'h0;
  logic [1:0] ph2 = 2'h0;
  logic sel_a = 1'b0;
  logic sel_b = 1'b1;
  logic axis_sel = 1'b0;
  logic [1:0] byte_sel = 2'h0;
  logic rd_en_n = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [7:0] rp;
  logic [7:0] ext;
  wire logic cp1, cp2, cc1, cc2, dir1, dir2, oe, wreq, irq;
  int num_errors = 0;
  int tests_run = 0;
  int n_cp1 = 0;
  int n_cc1 = 0;
  int idx1 = 0;
  int idx2 = 0;
  logic exp_dir = 1'b1;
  int n_cp2 = 0;
  int n_cc2 = 0;
  logic exp_dir2 = 1'b1;
  logic [3:0] be = 4'hf;
  logic test_pin = 1'b0;
  int m, k, n0;
  logic [31:0] d;

  always #4 clk = ~clk;

  qcop_top dut_u (.sys_clk_i(clk), .rst_n_i(rst_n), .axis1_chan_a_i(ph1[1]),
    .axis1_chan_b_i(ph1[0]), .axis2_chan_a_i(ph2[1]), .axis2_chan_b_i(ph2[0]),
    .count_mode_sel_a_i(sel_a), .count_mode_sel_b_i(sel_b), .axis_sel_i(axis_sel),
    .byte_sel_i(byte_sel), .read_en_n_i(rd_en_n), .test_i(test_pin),
    .axis1_count_pulse_o(cp1), .axis2_count_pulse_o(cp2), .axis1_carry_pulse_o(cc1),
    .axis2_carry_pulse_o(cc2), .axis1_direction_o(dir1), .axis2_direction_o(dir2),
    .read_port_o(rp), .read_port_oe_o(oe), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq));

  qcop_ext_cascade ext_u (.sys_clk_i(clk), .rst_n_i(rst_n), .carry_pulse_i(cc1),
    .direction_i(dir1), .ext_count_o(ext));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // counts of one quadrature cycle of four states in each mode
  function automatic int per_cycle(input int md);
    return (md == 1) ? 4 : (md == 2) ? 2 : 1;
  endfunction

  function automatic logic [1:0] gray(input int i);
    return {i[1], i[1] ^ i[0]};
  endfunction

  // pulses are counted by cycles high, so a stretched pulse shows up as extra counts
  always @(posedge clk)
    if (rst_n)
    begin
      n_cp1 += int'(cp1);
      n_cc1 += int'(cc1);
      if (cp1 === 1'b1 || cc1 === 1'b1)
        chk({31'h0, dir1}, {31'h0, exp_dir}, "axis1 direction");
      n_cp2 += int'(cp2);
      n_cc2 += int'(cc2);
      if (cp2 === 1'b1 || cc2 === 1'b1)
        chk({31'h0, dir2}, {31'h0, exp_dir2}, "axis2 direction");
    end

  task automatic step(input int ax, input int dn);
    if (ax == 1)
    begin
      idx1 += dn;
      ph1 <= gray(idx1);
    end
    else
    begin
      idx2 += dn;
      ph2 <= gray(idx2);
    end
    repeat (8) @(posedge clk);
  endtask

  // request held until waitrequest is low at a rising edge
  task automatic av_xfer(input logic w, input logic [4:0] a, input logic [31:0] v);
    adr <= a;
    wdat <= v;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic port_read(input logic s, input logic [31:0] e);
    axis_sel <= s;
    rd_en_n <= 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      byte_sel <= b[1:0];
      repeat (8) @(posedge clk);
      chk({31'h0, oe}, 32'h1, "port enable");
      chk({24'h0, rp}, {24'h0, e[31-8*b -: 8]}, "port byte");
    end
    rd_en_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({31'h0, oe}, 32'h0, "port released");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    k = $urandom(32'h8dae);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    av_xfer(1'b0, QCOP_OFS_CTRL, 32'h0);
    chk(d, QCOP_CTRL_RST, "ctrl reset");
    av_xfer(1'b0, QCOP_OFS_STATUS, 32'h0);
    chk(d, 32'h0, "status reset");
    av_xfer(1'b0, 5'h18, 32'h0);
    chk(d, 32'h0, "unmapped read");
    be <= 4'h0;
    av_xfer(1'b1, QCOP_OFS_MASK, 32'h7);
    be <= 4'hf;
    av_xfer(1'b0, QCOP_OFS_MASK, 32'h0);
    chk(d, 32'h0, "write without byte lane");
    $display("test registers done");
    // mode pins are settled before any step, as the host must
    for (m = 1; m <= 3; m++)
    begin
      {sel_a, sel_b} <= m[1:0];
      repeat (8) @(posedge clk);
      av_xfer(1'b1, QCOP_OFS_CTRL, 32'h7);
      k = $urandom_range(1, 4);
      n0 = n_cp1;
      repeat (4 * k) step(1, 1);
      av_xfer(1'b0, QCOP_OFS_POS1, 32'h0);
      chk(d, 32'(k * per_cycle(m)), "position");
      chk(32'(n_cp1 - n0), 32'(k * per_cycle(m)), "count pulses");
      av_xfer(1'b0, QCOP_OFS_MODE, 32'h0);
      chk(d, 32'(m), "mode");
      $display("test mode %0d done", m);
    end
    {sel_a, sel_b} <= 2'b01;
    repeat (8) @(posedge clk);
    av_xfer(1'b1, QCOP_OFS_CTRL, 32'h7);
    av_xfer(1'b1, QCOP_OFS_MASK, 32'h1);
    k = $urandom_range(1, 40);
    repeat (k) step(2, 1);
    exp_dir = 1'b0;
    n0 = n_cc1;
    repeat (3) step(1, -1);
    chk(32'(n_cc1 - n0), 32'h1, "underflow carry");
    chk({24'h0, ext}, 32'hff, "external count down");
    chk({31'h0, irq}, 32'h1, "irq raised");
    av_xfer(1'b0, QCOP_OFS_STATUS, 32'h0);
    chk(d, 32'h1, "carry status");
    port_read(1'b0, 32'hffff_fffd);
    port_read(1'b1, 32'(k));
    av_xfer(1'b1, QCOP_OFS_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test underflow and port done");
    exp_dir = 1'b1;
    av_xfer(1'b1, QCOP_OFS_MASK, 32'h0);
    repeat (3) step(1, 1);
    chk(32'(n_cc1 - n0), 32'h2, "overflow carry");
    chk({24'h0, ext}, 32'h0, "external count up");
    chk({31'h0, irq}, 32'h0, "irq masked");
    exp_dir2 = 1'b0;
    n0 = n_cc2;
    repeat (k + 1) step(2, -1);
    chk(32'(n_cc2 - n0), 32'h1, "axis2 underflow carry");
    chk(32'(n_cp2), 32'(2 * k + 1), "axis2 count pulses");
    $display("test axis2 underflow done");
    {sel_a, sel_b} <= 2'b00;
    repeat (8) @(posedge clk);
    n0 = n_cp1;
    step(1, 1);
    chk(32'(n_cp1 - n0), 32'h0, "no count when illegal");
    av_xfer(1'b0, QCOP_OFS_STATUS, 32'h0);
    chk(d, 32'h7, "illegal mode status");
    $display("test overflow and illegal mode done");
    give_verdict();
  end
endmodule
`default_nettype wire
